// *** hdl/gh_pkg.sv ***
// Purpose: Shared constants for the gauge host serial port.
// Assumes: Core clock mclk at 10 MHz.
// Notes:   Link times are device-side figures; cycle counts derive from them.
package gh_pkg;
   localparam int CLK_NS = 100;

   localparam logic [6:0] CTRL_IDX     = 7'h00;
   localparam logic [6:0] RW_TOP_IDX   = 7'h0F;
   localparam logic [6:0] UNLOCK_IDX   = 7'h6E;
   localparam logic [6:0] EE_LO_IDX    = 7'h76;
   localparam logic [6:0] EE_HI_IDX    = 7'h7F;
   localparam logic [6:0] I2C_DEV_ADDR = 7'b1010101;
   localparam logic [7:0] UNLOCK_KEY   = 8'hDD;
   localparam logic [7:0] FULL_RST_CMD = 8'h41;
   localparam logic [7:0] RESET_BYTE   = 8'h00;
   localparam logic [7:0] FILL_BYTE    = 8'hFF;
   localparam int         EE_BYTES     = 10;
   localparam int         REG_COUNT    = 128;
   localparam logic [3:0] LAST_BIT     = 4'h7;
   localparam logic [3:0] BYTE_BITS    = 4'h8;

   // Link times in microseconds; least times round up to whole cycles.
   localparam int BREAK_US      = 190;
   localparam int BREAK_REC_US  = 40;
   localparam int HOST_SAMPLE_US = 100;
   localparam int DEV_START_US  = 40;
   localparam int DEV_VALID_US  = 100;
   localparam int DEV_CYCLE_US  = 190;
   localparam int RESPONSE_US   = 200;
   localparam logic [15:0] BREAK_CYC     = 16'((BREAK_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] BREAK_REC_CYC = 16'((BREAK_REC_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] SAMPLE_CYC    = 16'((HOST_SAMPLE_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] DSTART_CYC    = 16'((DEV_START_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] DVALID_CYC    = 16'((DEV_VALID_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] DCYCLE_CYC    = 16'((DEV_CYCLE_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] RESPONSE_CYC  = 16'((RESPONSE_US * 1000 + CLK_NS - 1) / CLK_NS);

   // Long waits; the top module exposes their cycle counts as parameters.
   localparam longint SLEEP_S          = 18;
   localparam longint BUS_STUCK_MS     = 2;
   localparam longint SLEEP_CYC_DEF    = SLEEP_S * 1000000000 / CLK_NS;
   localparam longint STUCK_CYC_DEF    = BUS_STUCK_MS * 1000000 / CLK_NS;

   typedef enum logic [2:0] {H_IDLE, H_BIT, H_LOW, H_BRK, H_RESP, H_TX} gh_swl_st_t;
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_REG, I_WDAT, I_ACK, I_TX, I_MACK} gh_i2c_st_t;

   function automatic logic gh_is_ee(input logic [6:0] a);
      return (a >= EE_LO_IDX) && (a <= EE_HI_IDX);
   endfunction

   function automatic logic gh_is_rw(input logic [6:0] a);
      return (a <= RW_TOP_IDX) || gh_is_ee(a);
   endfunction
endpackage

// *** hdl/gh_serial_port.sv ***
// Purpose: Register access port of a battery gauge over a single-wire
//          return-to-one link and an I2C slave, with EEPROM programming.
// Assumes: Both engines run at once; unused lines are held high outside.
// Notes:   Open-drain pins drive low only; output enables are active low.
// What this block does
// - EEPROM writes refused until unlock key written.
// - New EEPROM values reach RAM at full reset.
// - Command byte selects register to write or read.
// - Bit 7 set writes, clear reads; index below.
// - Eight bits per byte, least significant first.
// - Long low is break; high recovery rearms.
// - Bits are start low, value, high tail.
// - Idle high between bits keeps transfer place.
// - Read data starts after the response delay.
// - Line output is open drain, low only.
// - I2C slave at fixed address, four formats.
// - Pointer advances per byte; quick read uses it.
// - Even read captures odd partner, pointer plus two.
// - Write to read-only register is NACKed, dropped.
// - Register index above top is NACKed.
// - Only first data byte per write is taken.
// - Stuck low lines released after timeout.
// - Sleep after long low and low activity.
`timescale 1ns/100ps
`default_nettype none
module gh_serial_port
   import gh_pkg::*;
#(
   parameter int unsigned SLEEP_CYC = 32'(SLEEP_CYC_DEF),
   parameter int unsigned STUCK_CYC = 32'(STUCK_CYC_DEF)
) (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic single_wire_line_in,
   output logic      single_wire_line_out,
   output logic      single_wire_line_oe_n,
   input  wire logic scl_in,
   output logic      scl_out,
   output logic      scl_oe_n,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe_n,
   input  wire logic program_voltage_pin,
   input  wire logic activity_below_threshold,
   output logic      eeprom_unlocked,
   output logic      sleep
);
   logic [1:0] rst_q;
   logic       rst_n;
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;
   logic       hl;
   logic       scl;
   logic       sda;
   logic       scl_rise;
   logic       scl_fall;
   logic       i2c_start;
   logic       i2c_stop;
   logic       pv_rise;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) rst_q <= 2'b00;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // Pin synchronisers; the third stage only serves edge detection.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 4'hF;
         s2_q <= 4'hF;
         s3_q <= 4'hF;
      end else begin
         s1_q <= {program_voltage_pin, sda_in, scl_in, single_wire_line_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign hl        = s2_q[0];
   assign scl       = s2_q[1];
   assign sda       = s2_q[2];
   assign scl_rise  = scl && !s3_q[1];
   assign scl_fall  = !scl && s3_q[1];
   assign i2c_start = scl && s3_q[1] && !sda && s3_q[2];
   assign i2c_stop  = scl && s3_q[1] && sda && !s3_q[2];
   assign pv_rise   = s2_q[3] && !s3_q[3];

   // Register file, EEPROM staging and EEPROM cells.
   logic [7:0] ram_q [REG_COUNT];
   logic [7:0] stage_q [EE_BYTES];
   logic [7:0] ee_q [EE_BYTES];
   logic       unlock_q;
   logic       boot_q;
   logic       hw_q;
   logic [6:0] hw_idx_q;
   logic [7:0] hw_dat_q;
   logic       iw_q;
   logic [6:0] iw_idx_q;
   logic [7:0] iw_dat_q;
   logic       wr_en;
   logic [6:0] wr_idx;
   logic [7:0] wr_dat;
   logic [3:0] wr_ee;
   logic       full_rst;

   function automatic logic [7:0] rd_val(input logic [6:0] a);
      if (a == UNLOCK_IDX) return RESET_BYTE;
      if (gh_is_ee(a) && unlock_q) return stage_q[4'(a - EE_LO_IDX)];
      return ram_q[a];
   endfunction

   function automatic logic wr_ok(input logic [6:0] a);
      return (a == UNLOCK_IDX) || (gh_is_rw(a) && (!gh_is_ee(a) || unlock_q));
   endfunction

   assign wr_en    = hw_q || iw_q;
   assign wr_idx   = hw_q ? hw_idx_q : iw_idx_q;
   assign wr_dat   = hw_q ? hw_dat_q : iw_dat_q;
   assign wr_ee    = 4'(wr_idx - EE_LO_IDX);
   assign full_rst = boot_q || (wr_en && wr_idx == CTRL_IDX && wr_dat == FULL_RST_CMD);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_q <= 1'b0;
         boot_q   <= 1'b1;
         for (int i = 0; i < REG_COUNT; i++) ram_q[i] <= RESET_BYTE;
         for (int i = 0; i < EE_BYTES; i++) stage_q[i] <= RESET_BYTE;
      end else begin
         boot_q <= 1'b0;
         if (wr_en && wr_idx == UNLOCK_IDX) begin
            unlock_q <= (wr_dat == UNLOCK_KEY);
            for (int i = 0; i < EE_BYTES; i++) stage_q[i] <= ee_q[i];
         end else if (wr_en && wr_ok(wr_idx)) begin
            if (gh_is_ee(wr_idx)) stage_q[wr_ee] <= wr_dat;
            else ram_q[wr_idx] <= wr_dat;
         end
         if (full_rst) begin
            for (int i = 0; i < EE_BYTES; i++) ram_q[EE_LO_IDX + 7'(i)] <= ee_q[i];
         end
      end
   end

   // The programming pulse commits staged bytes only while unlocked.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < EE_BYTES; i++) ee_q[i] <= RESET_BYTE;
      end else if (pv_rise && unlock_q) begin
         for (int i = 0; i < EE_BYTES; i++) ee_q[i] <= stage_q[i];
      end
   end

   // Single-wire engine.
   gh_swl_st_t h_st;
   logic [15:0] h_cnt;
   logic [2:0]  h_n;
   logic [7:0]  h_sh;
   logic        h_bit;
   logic        h_cmd_ok;
   logic [7:0]  h_cmd;
   logic [7:0]  h_tx;
   logic [7:0]  h_byte;
   logic        h_drive;

   assign h_byte = {h_bit, h_sh[7:1]};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         h_st     <= H_BRK;
         h_cnt    <= 16'h0000;
         h_n      <= 3'h0;
         h_sh     <= RESET_BYTE;
         h_bit    <= 1'b0;
         h_cmd_ok <= 1'b0;
         h_cmd    <= RESET_BYTE;
         h_tx     <= RESET_BYTE;
         hw_q     <= 1'b0;
         hw_idx_q <= 7'h00;
         hw_dat_q <= RESET_BYTE;
      end else begin
         hw_q <= 1'b0;
         case (h_st)
            H_IDLE: begin
               h_cnt <= 16'h0000;
               if (!hl) h_st <= H_BIT;
            end
            H_BIT: begin
               h_cnt <= h_cnt + 16'h0001;
               if (h_cnt == SAMPLE_CYC) begin
                  h_bit <= hl;
                  h_st  <= H_LOW;
               end
            end
            H_LOW: begin
               h_cnt <= h_cnt + 16'h0001;
               if (hl) begin
                  h_st <= H_IDLE;
                  h_sh <= h_byte;
                  h_n  <= h_n + 3'h1;
                  if (h_n == LAST_BIT[2:0]) begin
                     if (h_cmd_ok) begin
                        hw_q     <= 1'b1;
                        hw_idx_q <= h_cmd[6:0];
                        hw_dat_q <= h_byte;
                        h_cmd_ok <= 1'b0;
                     end else begin
                        h_cmd    <= h_byte;
                        h_cmd_ok <= h_byte[7];
                        // The response delay counts from the last command bit, not from its start.
                        if (!h_byte[7]) begin
                           h_st  <= H_RESP;
                           h_cnt <= 16'h0000;
                        end
                     end
                  end
               end else if (h_cnt >= BREAK_CYC) begin
                  h_st <= H_BRK;
               end
            end
            H_BRK: begin
               h_n      <= 3'h0;
               h_cmd_ok <= 1'b0;
               if (!hl) h_cnt <= 16'h0000;
               else if (h_cnt >= BREAK_REC_CYC) h_st <= H_IDLE;
               else h_cnt <= h_cnt + 16'h0001;
            end
            H_RESP: begin
               h_cnt <= h_cnt + 16'h0001;
               if (h_cnt == RESPONSE_CYC) begin
                  h_tx  <= rd_val(h_cmd[6:0]);
                  h_cnt <= 16'h0000;
                  h_n   <= 3'h0;
                  h_st  <= H_TX;
               end
            end
            H_TX: begin
               h_cnt <= h_cnt + 16'h0001;
               if (h_cnt == DCYCLE_CYC - 16'h0001) begin
                  h_cnt <= 16'h0000;
                  h_tx  <= {1'b0, h_tx[7:1]};
                  h_n   <= h_n + 3'h1;
                  if (h_n == LAST_BIT[2:0]) h_st <= H_IDLE;
               end
            end
            default: h_st <= H_BRK;
         endcase
      end
   end

   assign h_drive = (h_st == H_TX) &&
                    ((h_cnt < DSTART_CYC) || ((h_cnt < DVALID_CYC) && !h_tx[0]));
   assign single_wire_line_out  = 1'b0;
   assign single_wire_line_oe_n = !h_drive;

   // I2C slave engine.
   gh_i2c_st_t i_st;
   gh_i2c_st_t i_nxt;
   logic [7:0]  i_sh;
   logic [3:0]  i_n;
   logic [7:0]  i_ptr;
   logic [7:0]  i_tx;
   logic [7:0]  i_odd;
   logic        i_odd_ok;
   logic        i_ack;
   logic        i_first;
   logic [31:0] stuck_cnt;
   logic        stuck;
   logic        i_load;
   logic        i_byte;

   assign stuck  = stuck_cnt >= STUCK_CYC;
   assign i_byte = scl_fall && (i_n == BYTE_BITS);
   assign i_load = scl_fall && (((i_st == I_ACK) && (i_nxt == I_TX)) || (i_st == I_MACK));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) stuck_cnt <= 32'h0000_0000;
      else if (scl && sda) stuck_cnt <= 32'h0000_0000;
      else if (!stuck) stuck_cnt <= stuck_cnt + 32'h0000_0001;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         i_st     <= I_IDLE;
         i_nxt    <= I_IDLE;
         i_sh     <= RESET_BYTE;
         i_n      <= 4'h0;
         i_ptr    <= RESET_BYTE;
         i_tx     <= FILL_BYTE;
         i_odd    <= RESET_BYTE;
         i_odd_ok <= 1'b0;
         i_ack    <= 1'b0;
         i_first  <= 1'b0;
         iw_q     <= 1'b0;
         iw_idx_q <= 7'h00;
         iw_dat_q <= RESET_BYTE;
      end else begin
         iw_q <= 1'b0;
         if (stuck) begin
            i_st <= I_IDLE;
         end else if (i2c_start) begin
            i_st     <= I_ADDR;
            i_n      <= 4'h0;
            i_odd_ok <= 1'b0;
         end else if (i2c_stop) begin
            i_st <= I_IDLE;
         end else begin
            if (scl_rise && (i_st == I_ADDR || i_st == I_REG || i_st == I_WDAT)) begin
               i_sh <= {i_sh[6:0], sda};
               i_n  <= i_n + 4'h1;
            end
            if (scl_rise && i_st == I_MACK && sda) i_st <= I_IDLE;
            if (i_byte && i_st == I_ADDR) begin
               i_n   <= 4'h0;
               i_ack <= 1'b1;
               i_nxt <= i_sh[0] ? I_TX : I_REG;
               i_st  <= (i_sh[7:1] == I2C_DEV_ADDR) ? I_ACK : I_IDLE;
            end
            if (i_byte && i_st == I_REG) begin
               i_n     <= 4'h0;
               i_ack   <= !i_sh[7];
               i_nxt   <= i_sh[7] ? I_IDLE : I_WDAT;
               i_first <= 1'b1;
               if (!i_sh[7]) i_ptr <= i_sh;
               i_st    <= I_ACK;
            end
            if (i_byte && i_st == I_WDAT) begin
               i_n     <= 4'h0;
               i_first <= 1'b0;
               i_ack   <= i_first && wr_ok(i_ptr[6:0]);
               i_nxt   <= I_WDAT;
               i_st    <= I_ACK;
               if (i_first && wr_ok(i_ptr[6:0])) begin
                  iw_q     <= 1'b1;
                  iw_idx_q <= i_ptr[6:0];
                  iw_dat_q <= i_sh;
                  i_ptr    <= i_ptr + 8'h01;
               end
            end
            if (scl_fall && i_st == I_ACK) begin
               i_st  <= i_nxt;
               i_ack <= 1'b0;
               i_n   <= 4'h0;
            end
            if (scl_fall && i_st == I_TX) begin
               i_tx <= {i_tx[6:0], 1'b1};
               i_n  <= i_n + 4'h1;
               if (i_n == LAST_BIT) i_st <= I_MACK;
            end
            if (i_load) begin
               i_st <= I_TX;
               i_n  <= 4'h0;
               if (i_odd_ok) begin
                  i_tx     <= i_odd;
                  i_odd_ok <= 1'b0;
               end else if (i_ptr[7]) begin
                  i_tx <= FILL_BYTE;
               end else if (!i_ptr[0]) begin
                  i_tx     <= rd_val(i_ptr[6:0]);
                  i_odd    <= rd_val(i_ptr[6:0] | 7'h01);
                  i_odd_ok <= 1'b1;
                  i_ptr    <= i_ptr + 8'h02;
               end else begin
                  i_tx  <= rd_val(i_ptr[6:0]);
                  i_ptr <= i_ptr + 8'h01;
               end
            end
         end
      end
   end

   assign sda_out  = 1'b0;
   assign sda_oe_n = !(((i_st == I_ACK) && i_ack) || ((i_st == I_TX) && !i_tx[7]));
   assign scl_out  = 1'b0;
   assign scl_oe_n = 1'b1;

   // Sleep when any line has been low long enough and activity is low.
   logic [31:0] low_cnt;
   logic        sleep_q;
   logic        any_low;

   assign any_low = !hl || !scl || !sda;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= 32'h0000_0000;
         sleep_q <= 1'b0;
      end else if (!any_low) begin
         low_cnt <= 32'h0000_0000;
         sleep_q <= 1'b0;
      end else begin
         if (low_cnt < SLEEP_CYC) low_cnt <= low_cnt + 32'h0000_0001;
         else if (activity_below_threshold) sleep_q <= 1'b1;
      end
   end

   assign sleep           = sleep_q;
   assign eeprom_unlocked = unlock_q;
endmodule // gh_serial_port
`default_nettype wire

// *** test/gh_host_model.sv ***
// Purpose: Host side of the single-wire link and an I2C master.
// Assumes: Pull-ups sit in the testbench wiring.
// Notes:   A pull output high means the host drives that line low.
`timescale 1ns/100ps
`default_nettype none
module gh_host_model (
   input  wire logic mclk,
   input  wire logic sw_line,
   input  wire logic sda_line,
   output logic      sw_pull,
   output logic      scl_pull,
   output logic      sda_pull
);
   initial begin
      sw_pull  = 1'b0;
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic sw_break;
      sw_pull <= 1'b1;
      cyc(2500);
      sw_pull <= 1'b0;
      cyc(500);
   endtask
   task automatic sw_send(input logic [7:0] b, input int gap);
      for (int i = 0; i < 8; i++) begin
         sw_pull <= 1'b1;
         cyc(b[i] ? 300 : 1200);
         sw_pull <= 1'b0;
         cyc(b[i] ? 1000 : 400);
         if (i == 3)
            cyc(gap);
      end
   endtask
   // One byte per read; a 16-bit value takes high, low, then high again.
   task automatic sw_recv(output logic [7:0] b, output logic ok);
      int n;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         n = 0;
         while (sw_line && n < 4000) begin
            @(posedge mclk);
            n++;
         end
         if (n >= 4000)
            ok = 1'b0;
         cyc(700);
         b[i] = sw_line;
         n = 0;
         while (!sw_line && n < 2000) begin
            @(posedge mclk);
            n++;
         end
      end
   endtask
   // Also serves as repeated start when SCL is low.
   task automatic i2c_start;
      sda_pull <= 1'b0;
      cyc(6);
      scl_pull <= 1'b0;
      cyc(6);
      sda_pull <= 1'b1;
      cyc(6);
      scl_pull <= 1'b1;
      cyc(6);
   endtask
   task automatic i2c_stop;
      sda_pull <= 1'b1;
      cyc(6);
      scl_pull <= 1'b0;
      cyc(6);
      sda_pull <= 1'b0;
      cyc(6);
   endtask
   task automatic i2c_bit(input logic tx, output logic rx);
      sda_pull <= !tx;
      cyc(6);
      scl_pull <= 1'b0;
      cyc(6);
      rx = sda_line;
      scl_pull <= 1'b1;
      cyc(6);
   endtask
   task automatic i2c_byte(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--)
         i2c_bit(tx[i], rx[i]);
      i2c_bit(!mack, ack);
      ack = !ack;
   endtask
endmodule // gh_host_model
`default_nettype wire

// *** test/gh_port_chk_assertions.sv ***
// Purpose: Port assertions for the gauge serial port.
// Assumes: Sees only the top module ports; one clock domain.
// Notes:   Helper counters measure low and high spans of the lines.
`timescale 1ns/100ps
`default_nettype none
module gh_port_chk
   import gh_pkg::*;
#(
   parameter int unsigned SLEEP_CYC = 200,
   parameter int unsigned STUCK_CYC = 300
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic single_wire_line_in,
   input wire logic single_wire_line_out,
   input wire logic single_wire_line_oe_n,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic program_voltage_pin,
   input wire logic activity_below_threshold,
   input wire logic eeprom_unlocked,
   input wire logic sleep
);
   localparam int RESP_MIN = int'(RESPONSE_CYC);
   logic [31:0] lo_q;
   logic [31:0] hi_q;
   logic [31:0] sda_q;
   logic [31:0] quiet_q;
   logic        host_q;
   // The host_q flag remembers whether the last low span was the host's.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lo_q    <= '0;
         hi_q    <= '0;
         sda_q   <= '0;
         quiet_q <= '0;
         host_q  <= 1'b1;
      end else begin
         lo_q    <= single_wire_line_oe_n ? '0 : lo_q + 1;
         hi_q    <= single_wire_line_in ? hi_q + 1 : '0;
         sda_q   <= sda_oe_n ? '0 : sda_q + 1;
         quiet_q <= (scl_in && sda_in && single_wire_line_in) ? '0 : quiet_q + 1;
         if (!single_wire_line_in)
            host_q <= single_wire_line_oe_n;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_all_high;
      scl_in && sda_in && single_wire_line_in;
   endsequence
   sequence s_dev_start;
      $fell(single_wire_line_oe_n) && host_q;
   endsequence
   property p_od;
      !single_wire_line_out && !sda_out && scl_oe_n;
   endproperty
   property p_reset;
      $rose(arst_n) |-> single_wire_line_oe_n && sda_oe_n && !eeprom_unlocked && !sleep;
   endproperty
   property p_bit;
      $rose(single_wire_line_oe_n) |-> lo_q inside {[399:401], [999:1001]};
   endproperty
   property p_resp;
      s_dev_start |-> hi_q >= RESP_MIN;
   endproperty
   property p_span;
      $rose(sleep) |-> quiet_q >= SLEEP_CYC;
   endproperty
   property p_quiet;
      $rose(sleep) |-> $past(activity_below_threshold);
   endproperty
   property p_wake;
      s_all_high [*6] |-> !sleep;
   endproperty
   property p_stuck;
      sda_q <= STUCK_CYC + 8;
   endproperty
   a_od: assert property (p_od)
      else $error("open drain output drives high");
   a_reset: assert property (p_reset)
      else $error("outputs not cleared by reset");
   a_bit: assert property (p_bit)
      else $error("device bit low span wrong");
   a_resp: assert property (p_resp)
      else $error("read answer before response delay");
   a_span: assert property (p_span)
      else $error("sleep too early");
   a_quiet: assert property (p_quiet)
      else $error("sleep with battery activity");
   a_wake: assert property (p_wake)
      else $error("no wake with lines high");
   a_stuck: assert property (p_stuck)
      else $error("data line held past timeout");
endmodule // gh_port_chk
`default_nettype wire

// *** test/tb.sv ***
// Purpose: Self-checking bench for the gauge serial port.
// Assumes: Small sleep and stuck counts set at the instance.
// Notes:   Ordinary I2C cases run from a row table.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import gh_pkg::*;
   typedef struct packed {
      logic [7:0] r;
      logic [7:0] d;
      logic       a;
      logic [7:0] q;
   } gh_row_t;
   localparam gh_row_t ROWS [5] = '{
      '{8'h04, 8'h12, 1'b1, 8'h12},
      '{8'h05, 8'h34, 1'b1, 8'h34},
      '{8'h06, 8'h56, 1'b1, 8'h56},
      '{8'h20, 8'h77, 1'b0, 8'h00},
      '{8'h76, 8'h99, 1'b0, 8'h00}
   };
   logic mclk, arst_n, pvp, act, sw_in, sw_out, sw_oe_n;
   logic scl_in, scl_out, scl_oe_n, sda_in, sda_out, sda_oe_n;
   logic unl, slp, h_sw, h_scl, h_sda;
   int   err_total;
   int   checks;
   assign sw_in  = !(h_sw || !sw_oe_n);
   assign scl_in = !(h_scl || !scl_oe_n);
   assign sda_in = !(h_sda || !sda_oe_n);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   gh_serial_port #(.SLEEP_CYC(200), .STUCK_CYC(300)) uut (.mclk, .arst_n,
      .single_wire_line_in(sw_in), .single_wire_line_out(sw_out), .single_wire_line_oe_n(sw_oe_n),
      .scl_in, .scl_out, .scl_oe_n, .sda_in, .sda_out, .sda_oe_n, .program_voltage_pin(pvp),
      .activity_below_threshold(act), .eeprom_unlocked(unl), .sleep(slp));
   gh_host_model host (.mclk, .sw_line(sw_in), .sda_line(sda_in), .sw_pull(h_sw), .scl_pull(h_scl),
      .sda_pull(h_sda));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic i2c_wr(input logic [7:0] a, r, d, input logic two, output logic [3:0] k);
      logic [7:0] x;
      host.i2c_start();
      host.i2c_byte(a, 1'b0, x, k[3]);
      host.i2c_byte(r, 1'b0, x, k[2]);
      host.i2c_byte(d, 1'b0, x, k[1]);
      k[0] = 1'b0;
      if (two)
         host.i2c_byte(8'h22, 1'b0, x, k[0]);
      host.i2c_stop();
   endtask
   task automatic i2c_rd(input logic [7:0] r, output logic [7:0] d0, d1);
      logic [7:0] x;
      logic       k;
      host.i2c_start();
      host.i2c_byte(8'hAA, 1'b0, x, k);
      host.i2c_byte(r, 1'b0, x, k);
      host.i2c_start();
      host.i2c_byte(8'hAB, 1'b0, x, k);
      host.i2c_byte(8'hFF, 1'b1, d0, k);
      host.i2c_byte(8'hFF, 1'b0, d1, k);
      host.i2c_stop();
   endtask
   initial begin
      repeat (100000) @(posedge mclk);
      err_total++;
      final_report();
   end
   initial begin
      logic [7:0] b0, b1;
      logic [3:0] k;
      logic       ok;
      err_total = 0;
      checks = 0;
      arst_n = 1'b0;
      pvp = 1'b0;
      act = 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("unlock after reset", 8'h00, {7'h00, unl});
      host.sw_break();
      host.sw_send(8'h83, 2000);
      host.sw_send(8'h5A, 0);
      host.sw_send(8'h03, 0);
      host.sw_recv(b0, ok);
      chk("sw answer", 8'h01, {7'h00, ok});
      chk("sw read", 8'h5A, b0);
      i2c_rd(8'h03, b0, b1);
      chk("i2c read of sw write", 8'h5A, b0);
      $display("test single wire done");
      foreach (ROWS[i]) begin
         i2c_wr(8'hAA, ROWS[i].r, ROWS[i].d, 1'b0, k);
         chk("row data ack", {7'h00, ROWS[i].a}, {7'h00, k[1]});
         i2c_rd(ROWS[i].r, b0, b1);
         chk("row readback", ROWS[i].q, b0);
      end
      i2c_rd(8'h04, b0, b1);
      chk("pair low", 8'h12, b0);
      chk("pair high", 8'h34, b1);
      host.i2c_start();
      host.i2c_byte(8'hAB, 1'b0, b1, k[0]);
      host.i2c_byte(8'hFF, 1'b0, b0, k[0]);
      host.i2c_stop();
      chk("quick read", 8'h56, b0);
      i2c_wr(8'hA8, 8'h04, 8'h00, 1'b0, k);
      chk("foreign address ack", 8'h00, {7'h00, k[3]});
      i2c_wr(8'hAA, 8'h80, 8'h00, 1'b0, k);
      chk("index ack", 8'h00, {7'h00, k[2]});
      i2c_wr(8'hAA, 8'h07, 8'h11, 1'b1, k);
      chk("burst acks", 8'h0E, {4'h0, k});
      i2c_rd(8'h07, b0, b1);
      chk("first byte kept", 8'h11, b0);
      $display("test i2c done");
      i2c_wr(8'hAA, 8'h6E, 8'hDD, 1'b0, k);
      chk("unlocked", 8'h01, {7'h00, unl});
      i2c_wr(8'hAA, 8'h76, 8'h99, 1'b0, k);
      chk("cell write ack", 8'h01, {7'h00, k[1]});
      i2c_rd(8'h76, b0, b1);
      chk("cell staged", 8'h99, b0);
      pvp <= 1'b1;
      repeat (10) @(posedge mclk);
      pvp <= 1'b0;
      i2c_wr(8'hAA, 8'h6E, 8'h00, 1'b0, k);
      chk("locked", 8'h00, {7'h00, unl});
      i2c_rd(8'h76, b0, b1);
      chk("ram before full reset", 8'h00, b0);
      i2c_wr(8'hAA, 8'h00, 8'h41, 1'b0, k);
      repeat (20) @(posedge mclk);
      i2c_rd(8'h76, b0, b1);
      chk("ram after full reset", 8'h99, b0);
      i2c_rd(8'h7F, b0, b1);
      chk("map end", 8'hFF, b1);
      $display("test eeprom done");
      act <= 1'b1;
      host.scl_pull <= 1'b1;
      repeat (300) @(posedge mclk);
      chk("sleep", 8'h01, {7'h00, slp});
      host.scl_pull <= 1'b0;
      repeat (10) @(posedge mclk);
      chk("wake", 8'h00, {7'h00, slp});
      act <= 1'b0;
      host.i2c_start();
      for (int i = 7; i >= 0; i--)
         host.i2c_bit(i[0], b0[0]);
      repeat (400) @(posedge mclk);
      chk("sda released", 8'h01, {7'h00, sda_oe_n});
      chk("busy no sleep", 8'h00, {7'h00, slp});
      host.i2c_stop();
      $display("test sleep done");
      i2c_wr(8'hAA, 8'h6E, 8'hDD, 1'b0, k);
      chk("unlocked before reset", 8'h01, {7'h00, unl});
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("unlock after second reset", 8'h00, {7'h00, unl});
      $display("test reset done");
      final_report();
   end
endmodule // tb
bind gh_serial_port gh_port_chk #(.SLEEP_CYC(SLEEP_CYC), .STUCK_CYC(STUCK_CYC)) chk_i (.mclk, .arst_n,
   .single_wire_line_in, .single_wire_line_out, .single_wire_line_oe_n, .scl_in, .scl_out, .scl_oe_n,
   .sda_in, .sda_out, .sda_oe_n, .program_voltage_pin, .activity_below_threshold, .eeprom_unlocked, .sleep);
`default_nettype wire
